/* File: pkg/fsp_pkg.sv */
// Constants, types and register map of the flash sector protection block.
// Assumes one 50 MHz clock shared by the register port and the protection logic.
package fsp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned UNLOCK_GAP_NS = 100000;
  localparam int unsigned UNLOCK_GAP_CYCLES = (UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NV_OP_CYCLES = 16;
  localparam int unsigned GAP_CNT_W = 16;
  localparam int unsigned OP_CNT_W = 8;

  // ==========================================================
  // Array geometry
  localparam int unsigned NUM_SECTORS = 64;
  localparam int unsigned SECTOR_W = 6;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned SECTOR_LSB = 18;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RANGE = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_PWD_LO = 8'h10;
  localparam logic [7:0] OFS_PWD_HI = 8'h14;
  localparam logic [7:0] OFS_ADDR = 8'h18;
  localparam logic [7:0] OFS_SECTOR = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_VALUE_BIT = 4;
  localparam int unsigned CMD_DATA_LSB = 8;
  localparam int unsigned CMD_SECTOR_LSB = 16;
  localparam int unsigned CFG_MODE_LSB = 1;
  localparam int unsigned RANGE_BOTTOM_BIT = 3;

  // ==========================================================
  // Reset values and mode encodings
  localparam logic [7:0] CONFIG_RESET = 8'hff;
  localparam logic [63:0] PASSWORD_RESET = 64'hffff_ffff_ffff_ffff;
  localparam logic [1:0] MODE_NONE = 2'h3;
  localparam logic [1:0] MODE_PERSIST = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h0;

  // ==========================================================
  // Commands
  typedef enum logic [3:0] {
    FSP_OP_NOP = 4'h0,
    FSP_OP_NVG_PROGRAM = 4'h1,
    FSP_OP_NVG_ERASE = 4'h2,
    FSP_OP_VG_WRITE = 4'h3,
    FSP_OP_LOCK_CLEAR = 4'h4,
    FSP_OP_CFG_PROGRAM = 4'h5,
    FSP_OP_PWD_PROGRAM = 4'h6,
    FSP_OP_PWD_UNLOCK = 4'h7,
    FSP_OP_SOFT_RESET = 4'h8,
    FSP_OP_CLEAR_STATUS = 4'h9,
    FSP_OP_ARRAY_WRITE = 4'ha
  } fsp_op_type;

  // Embedded operation in progress
  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_NV_BUSY,
    FSP_ARRAY_BUSY
  } fsp_state_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fsp_bus_req_type;

  // Status pins
  typedef struct packed {
    logic write_in_progress;
    logic program_error;
    logic guard_bits_lock_bit;
    logic password_mode;
  } fsp_status_type;

endpackage

/* File: hw/fsp_top.sv */
// Sector protection logic of a serial flash: guard bits, lock, mode and password unlock.
// Assumes a command decoder on the same clock drives the register port; hw_reset_n_i is a pin.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// [RL1] Sector protected when range protection or per-sector guard protects it.
// [RL2] Each sector has a nonvolatile and a volatile guard; zero blocks writes.
// [RL3] Lock zero: nonvolatile guard program or erase fails, bits untouched.
// [RL4] Persistent mode sets lock at power-on or hardware reset; soft reset keeps it.
// [RL5] Lock-clear clears the lock; in persistent mode only resets set it again.
// [RL6] Password mode clears lock at reset; only a correct unlock sets it.
// [RL7] Mode bits 2:1: 11 default persistent, 10 persistent, 01 password.
// [RL8] Programming both mode bits to zero is a programming failure.
// [RL9] After a mode is chosen the configuration register cannot change.
// [RL10] Host programs the password before selecting password mode.
// [RL11] Fresh device: persistent mode and every sector unprotected.
// [RL12] Write-in-progress stays set while the configuration is programmed.
// [RL13] Nonvolatile guards program to zero singly; erase sets all to one.
// [RL14] Volatile guard counts only where nonvolatile is one; write sets or clears.
// [RL15] Volatile guards return to unprotected on power, soft or hardware reset.
// [RL16] Nonvolatile guards change only with lock one; volatile ones always.
// [RL17] Password is 64 bits, all ones at first, any value valid.
// [RL18] Password program only clears bits; writing one over zero is silent.
// [RL19] In password mode password read and program are ignored.
// [RL20] Matching unlock sets lock; mismatch sets error and keeps busy.
// [RL21] Unlock taken at most once per 100 us; success ends busy at once.
// [RL22] Array write allowed only outside range and with both guards one.
// [RL23] Sector of each array write request is decoded before it starts.
module fsp_top
  import fsp_pkg::*;
#(
  parameter int unsigned UNLOCK_GAP = fsp_pkg::UNLOCK_GAP_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_n_i,
  // Register port
  input wire fsp_pkg::fsp_bus_req_type bus_i,
  output logic [31:0] rdata_o,
  // Status
  output fsp_pkg::fsp_status_type status_o,
  output logic array_op_start_o
);
  import fsp_pkg::*;

  // ==========================================================
  // Reset synchronisers
  logic rst_meta;
  logic rst_n;
  logic hw_meta;
  logic hw_sync_n;

  // Release of the asynchronous reset is retimed
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Hardware reset pin, two flops before use
  // Resets high so release shows no false pin reset
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hw_meta <= 1'b1;
      hw_sync_n <= 1'b1;
    end
    else
    begin
      hw_meta <= hw_reset_n_i;
      hw_sync_n <= hw_meta;
    end
  end

  wire hw_rst = !hw_sync_n;

  // ==========================================================
  // Storage
  logic [NUM_SECTORS-1:0] nv_guard;
  logic [NUM_SECTORS-1:0] v_guard;
  logic lock_bit;
  logic [7:0] config_reg;
  logic [63:0] password;
  logic [63:0] pwd_stage;
  logic [3:0] range_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic prog_err;
  fsp_state_type state;
  logic [OP_CNT_W-1:0] op_cnt;
  logic [GAP_CNT_W-1:0] gap_cnt;
  logic [NUM_SECTORS-1:0] range_mask;

  // ==========================================================
  // Decoding helpers

  // Range coverage of one sector; 64th up to all sectors
  // Bottom bit moves the window to start at sector zero
  function automatic logic range_hit(input logic [3:0] rng, input logic [SECTOR_W-1:0] sec);
    logic [SECTOR_W:0] count;
    logic [SECTOR_W:0] idx;
    count = '0;
    idx = {1'b0, sec};
    if (rng[2:0] == 3'h7)
      count = (SECTOR_W+1)'(NUM_SECTORS);
    else if (rng[2:0] != 3'h0)
      count = (SECTOR_W+1)'(1) << (rng[2:0] - 3'h1);
    if (rng[RANGE_BOTTOM_BIT])
      range_hit = idx < count;
    else
      range_hit = idx >= ((SECTOR_W+1)'(NUM_SECTORS) - count);
  endfunction

  // Sector index of a byte address
  function automatic logic [SECTOR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    sector_of = a[SECTOR_LSB +: SECTOR_W];
  endfunction

  // ==========================================================
  // Command decode
  wire is_cmd = bus_i.wr && (bus_i.addr == OFS_COMMAND);
  wire [3:0] cmd_op = bus_i.wdata[CMD_OP_LSB +: 4];
  wire cmd_value = bus_i.wdata[CMD_VALUE_BIT];
  wire [7:0] cmd_data = bus_i.wdata[CMD_DATA_LSB +: 8];
  wire [SECTOR_W-1:0] cmd_sector = bus_i.wdata[CMD_SECTOR_LSB +: SECTOR_W];
  wire [1:0] mode = config_reg[CFG_MODE_LSB +: 2];
  wire password_mode = (mode == MODE_PASSWORD); // RL7
  wire mode_chosen = (mode != MODE_NONE); // RL7
  wire busy = (state != FSP_IDLE) || prog_err;
  // While busy only status handling and soft reset pass
  // Commands are also dropped during a pin reset, since the timer is held
  // idle then and nothing would show busy for the change
  wire accept = is_cmd && !busy && !hw_rst;
  wire [SECTOR_W-1:0] req_sector = sector_of(addr_reg); // RL23

  // Per-sector range map
  always_comb
  begin
    for (int s = 0; s < NUM_SECTORS; s++)
      range_mask[s] = range_hit(range_reg, SECTOR_W'(s));
  end

  // Both schemes ORed; a zero guard protects
  wire req_ok = !range_mask[req_sector] && nv_guard[req_sector] && v_guard[req_sector]; // RL1 RL2 RL22

  wire do_nvg_prog = accept && (cmd_op == FSP_OP_NVG_PROGRAM);
  wire do_nvg_erase = accept && (cmd_op == FSP_OP_NVG_ERASE);
  wire do_cfg = accept && (cmd_op == FSP_OP_CFG_PROGRAM);
  wire do_pwd_prog = accept && (cmd_op == FSP_OP_PWD_PROGRAM) && !password_mode; // RL19
  wire do_unlock = accept && (cmd_op == FSP_OP_PWD_UNLOCK) && password_mode && (gap_cnt == '0); // RL21
  wire do_array = accept && (cmd_op == FSP_OP_ARRAY_WRITE);
  wire do_soft = is_cmd && (cmd_op == FSP_OP_SOFT_RESET);
  wire do_clr = is_cmd && (cmd_op == FSP_OP_CLEAR_STATUS);
  wire nv_locked = (do_nvg_prog || do_nvg_erase) && !lock_bit; // RL3 RL16
  wire cfg_bad = do_cfg && (mode_chosen || (cmd_data[CFG_MODE_LSB +: 2] == MODE_ILLEGAL)); // RL8 RL9
  wire unlock_bad = do_unlock && (pwd_stage != password); // RL20
  wire array_bad = do_array && !req_ok; // RL22
  wire any_fail = nv_locked || cfg_bad || unlock_bad || array_bad;

  // ==========================================================
  // Embedded operation timer
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= FSP_IDLE;
      op_cnt <= '0;
    end
    else if (hw_rst)
    begin
      state <= FSP_IDLE;
      op_cnt <= '0;
    end
    else
    begin
      unique case (state)
        FSP_IDLE:
        begin
          // Busy held for the whole program time
          // Loaded one short, as the zero count is a busy cycle too
          if ((do_nvg_prog || do_nvg_erase || do_cfg || do_pwd_prog) && !any_fail) // RL12
          begin
            state <= FSP_NV_BUSY;
            op_cnt <= OP_CNT_W'(NV_OP_CYCLES - 1);
          end
          else if (do_array && req_ok)
          begin
            state <= FSP_ARRAY_BUSY;
            op_cnt <= OP_CNT_W'(NV_OP_CYCLES - 1);
          end
        end
        FSP_NV_BUSY, FSP_ARRAY_BUSY:
        begin
          if (op_cnt == '0)
            state <= FSP_IDLE;
          else
            op_cnt <= op_cnt - OP_CNT_W'(1);
        end
        default:
          state <= FSP_IDLE;
      endcase
    end
  end

  // Start strobe toward the array sequencer
  assign array_op_start_o = do_array && req_ok; // RL22

  // ==========================================================
  // Program error flag; it also keeps busy up until cleared
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prog_err <= 1'b0;
    else if (hw_rst)
      prog_err <= 1'b0;
    else if (any_fail) // RL20
      prog_err <= 1'b1;
    else if (do_clr || do_soft)
      prog_err <= 1'b0;
  end

  // ==========================================================
  // Unlock rate limiter; runs whether the try matched or not
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      gap_cnt <= '0;
    else if (hw_rst)
      gap_cnt <= '0;
    else if (do_unlock)
      gap_cnt <= GAP_CNT_W'(UNLOCK_GAP - 1); // RL21
    else if (gap_cnt != '0)
      gap_cnt <= gap_cnt - GAP_CNT_W'(1);
  end

  // ==========================================================
  // Lock bit
  // Power-on always gives the fresh persistent default, lock one
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      lock_bit <= 1'b1; // RL4 RL11
    else if (hw_rst)
      lock_bit <= !password_mode; // RL4 RL6
    else if (do_unlock && !unlock_bad)
      lock_bit <= 1'b1; // RL6 RL20
    else if (accept && (cmd_op == FSP_OP_LOCK_CLEAR))
      lock_bit <= 1'b0; // RL5
  end

  // ==========================================================
  // Nonvolatile guards; survive hardware and soft reset
  // With lock zero the bits stay; the error flag reports the try
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      nv_guard <= '1; // RL11
    else if (do_nvg_prog && lock_bit)
      nv_guard[cmd_sector] <= 1'b0; // RL13 RL16
    else if (do_nvg_erase && lock_bit)
      nv_guard <= '1; // RL13
  end

  // ==========================================================
  // Volatile guards; writable regardless of lock
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      v_guard <= '1; // RL15
    else if (hw_rst || do_soft)
      v_guard <= '1; // RL15
    else if (accept && (cmd_op == FSP_OP_VG_WRITE))
      v_guard[cmd_sector] <= cmd_value; // RL14 RL16
  end

  // ==========================================================
  // Configuration register, one-time programmable
  // Bits only move to zero; nothing here can set them again
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      config_reg <= CONFIG_RESET; // RL11
    else if (do_cfg && !cfg_bad)
      config_reg <= config_reg & cmd_data; // RL7 RL9
  end

  // ==========================================================
  // Hidden password; bits only ever go to zero
  // Readback is hidden in the read mux, not here
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      password <= PASSWORD_RESET; // RL17
    else if (do_pwd_prog)
      password <= password & pwd_stage; // RL18
  end

  // ==========================================================
  // Software-written staging and control registers
  // Loads ignore busy, so staging may be filled during an operation
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwd_stage <= '0;
      range_reg <= '0;
      addr_reg <= '0;
    end
    else if (bus_i.wr)
    begin
      if (bus_i.addr == OFS_PWD_LO)
        pwd_stage[31:0] <= bus_i.wdata;
      if (bus_i.addr == OFS_PWD_HI)
        pwd_stage[63:32] <= bus_i.wdata;
      if (bus_i.addr == OFS_RANGE)
        range_reg <= bus_i.wdata[3:0];
      if (bus_i.addr == OFS_ADDR)
        addr_reg <= bus_i.wdata[ADDR_W-1:0];
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe, zero otherwise
  // Unmapped offsets read zero; the port has no error response
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= '0;
    else if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        OFS_STATUS:
          rdata_o <= {28'h0, password_mode, lock_bit, prog_err, busy};
        OFS_RANGE:
          rdata_o <= {28'h0, range_reg};
        OFS_CONFIG:
          rdata_o <= {24'h0, config_reg};
        // Password is hidden once password mode is set
        OFS_PWD_LO:
          rdata_o <= password_mode ? 32'h0 : password[31:0]; // RL19
        OFS_PWD_HI:
          rdata_o <= password_mode ? 32'h0 : password[63:32]; // RL19
        OFS_ADDR:
          rdata_o <= {8'h0, addr_reg};
        OFS_SECTOR:
          rdata_o <= {28'h0, req_ok, range_mask[req_sector], v_guard[req_sector], nv_guard[req_sector]};
        default:
          rdata_o <= 32'h0;
      endcase
    end
    else
      rdata_o <= 32'h0;
  end

  // Status pins track internal state directly
  // Combinational pins trade a gate path for no extra status latency
  assign status_o.write_in_progress = busy;
  assign status_o.program_error = prog_err;
  assign status_o.guard_bits_lock_bit = lock_bit;
  assign status_o.password_mode = password_mode;

endmodule

`default_nettype wire

/* File: verification/fsp_host.sv */
// Register-port host model that issues protection commands.
// Assumes the bench calls wr and rd one at a time.
`timescale 1ns/1ns
`default_nettype none
module fsp_host
  import fsp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port
  output fsp_pkg::fsp_bus_req_type bus_o,
  input wire logic [31:0] rdata_i
);
  // ====================
  // Bus cycles
  // Idle port starts quiet
  initial bus_o = '0;

  // Write; released lines turn over so stale values never help
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  end
  endtask

  // Read; data taken in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
  begin
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_o <= '{addr: ~a, wdata: 32'hffffffff, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  end
  endtask
endmodule
`default_nettype wire

/* File: verification/fsp_top_assertions.sv */
// Port checker of the sector protection block.
// Assumes one clock; bound to every fsp_top instance.
`timescale 1ns/1ns
`default_nettype none
module fsp_top_chk
  import fsp_pkg::*;
#(
  parameter int unsigned UNLOCK_GAP = 20
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_n_i,
  // Observed ports
  input wire fsp_pkg::fsp_bus_req_type bus_i,
  input wire logic [31:0] rdata_o,
  input wire fsp_pkg::fsp_status_type status_o,
  input wire logic array_op_start_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ====================
  // Helpers
  // Command decode and status in register bit order
  logic cmd_wr;
  logic [3:0] st;
  assign cmd_wr = bus_i.wr && (bus_i.addr == OFS_COMMAND);
  assign st = {status_o.password_mode, status_o.guard_bits_lock_bit, status_o.program_error,
    status_o.write_in_progress};
  logic unlock_try;
  int unlock_wait;
  assign unlock_try = cmd_wr && bus_i.wdata[3:0] == FSP_OP_PWD_UNLOCK && status_o.password_mode &&
    !status_o.write_in_progress;

  // Unlock spacing window; a pin reset empties it early, which only mutes the check
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      unlock_wait <= 0;
    else if (!hw_reset_n_i)
      unlock_wait <= 0;
    else if (unlock_try && unlock_wait == 0)
      unlock_wait <= int'(UNLOCK_GAP) - 1;
    else if (unlock_wait != 0)
      unlock_wait <= unlock_wait - 1;
  end

  // ====================
  // Properties
  a_status_read: assert property (bus_i.rd && bus_i.addr == OFS_STATUS |=>
    rdata_o == {28'h0, $past(st)}) else $error("status read differs");
  a_start_cause: assert property (array_op_start_o |-> cmd_wr &&
    bus_i.wdata[3:0] == FSP_OP_ARRAY_WRITE && !status_o.write_in_progress) else $error("bad start");
  a_start_busy: assert property (array_op_start_o |=>
    status_o.write_in_progress [*8]) else $error("start without busy");
  a_nv_busy: assert property (cmd_wr && !status_o.write_in_progress && bus_i.wdata[3:0] inside
    {FSP_OP_NVG_PROGRAM, FSP_OP_NVG_ERASE, FSP_OP_CFG_PROGRAM} |=> status_o.write_in_progress [*8])
    else $error("busy too short");
  a_err_busy: assert property (status_o.program_error |->
    status_o.write_in_progress) else $error("error without busy");
  a_err_clear: assert property (cmd_wr && bus_i.wdata[3:0] inside
    {FSP_OP_SOFT_RESET, FSP_OP_CLEAR_STATUS} |=> !status_o.program_error) else $error("error kept");
  a_mode_sticky: assert property (status_o.password_mode |=>
    status_o.password_mode) else $error("mode changed");
  a_lock_persist: assert property ($rose(status_o.guard_bits_lock_bit) && !status_o.password_mode |->
    !$past(hw_reset_n_i, 2) || !$past(hw_reset_n_i, 3) || !$past(hw_reset_n_i, 4))
    else $error("lock set by command");
  a_pwd_hw_lock: assert property ((status_o.password_mode && !hw_reset_n_i) [*4] |=>
    !status_o.guard_bits_lock_bit) else $error("lock not cleared");
  a_per_hw_lock: assert property ((!status_o.password_mode && !hw_reset_n_i) [*4] |=>
    status_o.guard_bits_lock_bit) else $error("lock not set");
  a_unlock_gap: assert property (unlock_try && unlock_wait != 0 |=>
    $stable(status_o.guard_bits_lock_bit) && !$rose(status_o.program_error)) else $error("unlock inside gap");

  // Main scenarios reached
  c_start: cover property (array_op_start_o);
  c_mode: cover property ($rose(status_o.password_mode));
  c_err: cover property ($rose(status_o.program_error));
endmodule

bind fsp_top fsp_top_chk #(.UNLOCK_GAP(UNLOCK_GAP)) i_fsp_top_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .hw_reset_n_i(hw_reset_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .status_o(status_o),
  .array_op_start_o(array_op_start_o));
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the sector protection block.
// Assumes fsp_host drives the register port and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import fsp_pkg::*;
;
  // ====================
  // Clock, reset, wiring
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hw_reset_n_i = 1'b1;
  fsp_bus_req_type bus_i;
  logic [31:0] rdata_o;
  fsp_status_type status_o;
  logic array_op_start_o;
  int err_count = 0;
  int total_checks = 0;
  int start_count = 0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // Count start pulses as the design samples them
  always @(posedge clk_i)
    if (array_op_start_o)
      start_count++;

  // Short unlock gap keeps the run brief
  fsp_top #(.UNLOCK_GAP(20)) i_fsp_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .hw_reset_n_i(hw_reset_n_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .status_o(status_o), .array_op_start_o(array_op_start_o));
  fsp_host i_host (.clk_i(clk_i), .bus_o(bus_i), .rdata_i(rdata_o));

  // ====================
  // Shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
  begin
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, s, e);
    end
  end
  endtask

  task automatic rx(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
  begin
    i_host.rd(a, d);
    chk(d, e);
  end
  endtask

  // Poll busy with a bound; failed ops stay busy
  task automatic cmd(input logic [3:0] op, input logic [31:0] arg);
    logic [31:0] d;
  begin
    i_host.wr(OFS_COMMAND, arg | {28'h0, op});
    for (int n = 0; n < 30; n++)
    begin
      i_host.rd(OFS_STATUS, d);
      if (d[0] !== 1'b1)
        break;
    end
  end
  endtask

  task automatic pw(input logic [31:0] hi, input logic [31:0] lo);
  begin
    i_host.wr(OFS_PWD_LO, lo);
    i_host.wr(OFS_PWD_HI, hi);
  end
  endtask

  // Pin reset long enough to pass the synchroniser
  task automatic hwr();
  begin
    @(posedge clk_i);
    hw_reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    hw_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  end
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
  begin
    rx(OFS_STATUS, 32'h4);
    chk(status_o, 32'h2);
    rx(OFS_CONFIG, 32'hff);
    rx(OFS_SECTOR, 32'hb);
    rx(OFS_PWD_LO, 32'hffffffff);
    rx(8'h20, 32'h0);
    $display("test reset done");
  end
  endtask

  task automatic t_guards();
  begin
    i_host.wr(OFS_ADDR, 32'h140000);
    cmd(FSP_OP_NVG_PROGRAM, 32'h50000);
    rx(OFS_SECTOR, 32'h2);
    cmd(FSP_OP_ARRAY_WRITE, 32'h0);
    rx(OFS_STATUS, 32'h7);
    cmd(FSP_OP_CLEAR_STATUS, 32'h0);
    cmd(FSP_OP_NVG_ERASE, 32'h0);
    rx(OFS_SECTOR, 32'hb);
    cmd(FSP_OP_VG_WRITE, 32'h50000);
    rx(OFS_SECTOR, 32'h1);
    cmd(FSP_OP_SOFT_RESET, 32'h0);
    rx(OFS_SECTOR, 32'hb);
    cmd(FSP_OP_ARRAY_WRITE, 32'h0);
    rx(OFS_STATUS, 32'h4);
    chk(start_count, 32'h1);
    $display("test guards done");
  end
  endtask

  task automatic t_range();
  begin
    i_host.wr(OFS_RANGE, 32'h7);
    rx(OFS_SECTOR, 32'h7);
    i_host.wr(OFS_RANGE, 32'h1);
    rx(OFS_SECTOR, 32'hb);
    i_host.wr(OFS_ADDR, 32'hfc0000);
    rx(OFS_SECTOR, 32'h7);
    i_host.wr(OFS_RANGE, 32'h0);
    rx(OFS_SECTOR, 32'hb);
    i_host.wr(OFS_ADDR, 32'h140000);
    i_host.wr(OFS_RANGE, 32'he);
    rx(OFS_SECTOR, 32'h7);
    i_host.wr(OFS_RANGE, 32'h0);
    rx(OFS_SECTOR, 32'hb);
    $display("test range done");
  end
  endtask

  task automatic t_lock();
  begin
    cmd(FSP_OP_LOCK_CLEAR, 32'h0);
    rx(OFS_STATUS, 32'h0);
    cmd(FSP_OP_NVG_PROGRAM, 32'h50000);
    rx(OFS_STATUS, 32'h3);
    cmd(FSP_OP_CLEAR_STATUS, 32'h0);
    rx(OFS_SECTOR, 32'hb);
    cmd(FSP_OP_VG_WRITE, 32'h50000);
    rx(OFS_SECTOR, 32'h1);
    cmd(FSP_OP_VG_WRITE, 32'h50010);
    rx(OFS_SECTOR, 32'hb);
    cmd(FSP_OP_SOFT_RESET, 32'h0);
    rx(OFS_STATUS, 32'h0);
    hwr();
    rx(OFS_STATUS, 32'h4);
    $display("test lock done");
  end
  endtask

  task automatic t_mode();
  begin
    cmd(FSP_OP_CFG_PROGRAM, 32'hf900);
    rx(OFS_STATUS, 32'h7);
    cmd(FSP_OP_CLEAR_STATUS, 32'h0);
    rx(OFS_CONFIG, 32'hff);
    // Password goes in before the mode is chosen
    pw(32'ha5a5a5a5, 32'h3c3c3c3c);
    cmd(FSP_OP_PWD_PROGRAM, 32'h0);
    pw(32'hffffffff, 32'h0f0f0f0f);
    cmd(FSP_OP_PWD_PROGRAM, 32'h0);
    rx(OFS_PWD_LO, 32'h0c0c0c0c);
    rx(OFS_STATUS, 32'h4);
    cmd(FSP_OP_CFG_PROGRAM, 32'hfb00);
    rx(OFS_CONFIG, 32'hfb);
    rx(OFS_STATUS, 32'hc);
    rx(OFS_PWD_HI, 32'h0);
    cmd(FSP_OP_CFG_PROGRAM, 32'hfd00);
    rx(OFS_STATUS, 32'hf);
    cmd(FSP_OP_CLEAR_STATUS, 32'h0);
    rx(OFS_CONFIG, 32'hfb);
    hwr();
    rx(OFS_STATUS, 32'h8);
    pw(32'h0, 32'h0);
    cmd(FSP_OP_PWD_PROGRAM, 32'h0);
    rx(OFS_STATUS, 32'h8);
    // Zeros staged: mismatch, then a correct try inside the gap
    i_host.wr(OFS_COMMAND, 32'h7);
    rx(OFS_STATUS, 32'hb);
    i_host.wr(OFS_COMMAND, 32'h9);
    pw(32'ha5a5a5a5, 32'h0c0c0c0c);
    i_host.wr(OFS_COMMAND, 32'h7);
    rx(OFS_STATUS, 32'h8);
    repeat (25) @(posedge clk_i);
    i_host.wr(OFS_COMMAND, 32'h7);
    rx(OFS_STATUS, 32'hc);
    $display("test mode done");
  end
  endtask

  // ====================
  // Run control
  task automatic complete_run();
  begin
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_guards();
    t_range();
    t_lock();
    t_mode();
    complete_run();
  end

  // Watchdog well past the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
